/* File: rtl/imh_handler.v */
`include "imh_consts.vh"
`default_nettype none

module imh_handler (
  input  wire        sys_clk,       // clock, 10 MHz
  input  wire        rstn,          // async reset, active low
  input  wire        qmove_valid,   // quad move presented
  input  wire [31:0] qmove_addr,    // quad move destination
  input  wire [31:0] qmove_w0,      // message word 0
  input  wire [31:0] qmove_w1,      // message word 1 (field 3)
  input  wire [31:0] qmove_w2,      // message word 2
  input  wire [31:0] qmove_w3,      // message word 3
  input  wire [31:0] cur_pcb_sel,   // selector of current block
  input  wire [31:0] cur_pcb_base,  // memory base of that block
  input  wire [1:0]  proc_state,    // processor state
  input  wire        is_init_proc,  // this is the initializer
  input  wire        call_valid,    // frame allocated to a set
  input  wire [1:0]  call_set,      // set given to the new frame
  input  wire [31:0] call_fp,       // frame address
  input  wire        ret_valid,     // return into a set
  input  wire [1:0]  ret_set,       // set of the frame returned to
  input  wire        lr_we,         // core register write
  input  wire [5:0]  lr_waddr,      // {set, index}
  input  wire [31:0] lr_wdata,      // core write data
  input  wire [5:0]  lr_raddr,      // {set, index}
  output wire [31:0] lr_rdata,      // cache read data, registered
  input  wire        mem_ack,       // memory cycle done, pulse
  input  wire [31:0] mem_rdata,     // memory read data
  output reg         mem_req,       // memory request, held
  output reg         mem_we,        // memory write
  output reg  [31:0] mem_addr,      // memory address
  output reg  [31:0] mem_wdata,     // memory write data
  output reg         msg_ready,     // handler can take work
  output reg         irq_hold,      // interrupt pins ignored
  output reg         event_fault,   // event-notice fault, pulse
  output reg         go_idle,       // enter idle state, pulse
  output reg         go_stopped,    // enter stopped state, pulse
  output reg         start_init,    // run init from ROM, pulse
  output reg  [3:0]  set_purged     // per-set purged flags
);

  // ========================================================
  // States
  localparam [3:0] ST_IDLE   = 4'h0;
  localparam [3:0] ST_NC_RD  = 4'h1;
  localparam [3:0] ST_NC_WR  = 4'h2;
  localparam [3:0] ST_FL_RD  = 4'h3;
  localparam [3:0] ST_FL_DAT = 4'h4;
  localparam [3:0] ST_FL_WR  = 4'h5;
  localparam [3:0] ST_FL_MRK = 4'h6;
  localparam [3:0] ST_RL     = 4'h7;
  localparam [3:0] ST_DONE   = 4'h8;

  // ========================================================
  // Helpers
  function [31:0] word_addr;
    input [31:0] base;
    input [3:0]  idx;
    begin
      word_addr = base + {{26{1'b0}}, idx, 2'b00};
    end
  endfunction

  function same_page;
    input [31:0] a;
    input [31:0] b;
    begin
      same_page = (a[31:`IMH_PAGE_LSB] == b[31:`IMH_PAGE_LSB]);
    end
  endfunction

  // ========================================================
  // State
  reg [3:0]  state;
  reg [31:0] set_fp [0:3];
  reg [3:0]  set_valid;
  reg [1:0]  active_set;
  reg [1:0]  set_cnt;
  reg [3:0]  word_cnt;
  reg        page_hit;
  reg        c_we;
  reg [5:0]  c_waddr;
  reg [31:0] c_wdata;
  reg [5:0]  c_raddr;
  integer    i;
  integer    j;

  wire [7:0] msg_type = qmove_w0[`IMH_TYPE_MSB:`IMH_TYPE_LSB];
  wire       msg_in   = qmove_valid &&
                        (qmove_addr == `IMH_MSG_ADDR);
  wire       sel_ok   = (qmove_w1 == 32'h00000000) ||
                        (qmove_w1 == cur_pcb_sel);
  wire       no_flush = (proc_state == `IMH_PS_IDLE) ||
                        (proc_state == `IMH_PS_STOP);
  wire       last_wd  = (word_cnt == `IMH_LAST_WORD);
  wire [1:0] nxt_set  = set_cnt + 2'h1;

  // Any valid set whose frame lies in the named page
  always @* begin
    page_hit = 1'b0;
    for (j = 0; j < `IMH_SETS; j = j + 1) begin
      if (set_valid[j] && same_page(set_fp[j], qmove_w1)) begin
        page_hit = 1'b1;
      end
    end
  end

  // ========================================================
  // Cache port steering; core writes only while idle
  always @* begin
    c_we    = 1'b0;
    c_waddr = lr_waddr;
    c_wdata = lr_wdata;
    c_raddr = lr_raddr;
    if (state == ST_RL) begin
      c_we    = mem_req && mem_ack;
      c_waddr = {set_cnt, word_cnt};
      c_wdata = mem_rdata;
    end else if (state == ST_IDLE) begin
      c_we    = lr_we;
    end
    if (state == ST_FL_RD) begin
      c_raddr = {set_cnt, word_cnt};
    end
  end

  imh_regcache u_cache (
    .sys_clk (sys_clk),
    .we      (c_we),
    .waddr   (c_waddr),
    .wdata   (c_wdata),
    .raddr   (c_raddr),
    .rdata   (lr_rdata)
  );

  // ========================================================
  // Message sequencer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state       <= ST_IDLE;
      set_valid   <= 4'h0;
      set_purged  <= 4'h0;
      active_set  <= 2'h0;
      set_cnt     <= 2'h0;
      word_cnt    <= 4'h0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 32'h00000000;
      mem_wdata   <= 32'h00000000;
      msg_ready   <= 1'b1;
      irq_hold    <= 1'b0;
      event_fault <= 1'b0;
      go_idle     <= 1'b0;
      go_stopped  <= 1'b0;
      start_init  <= 1'b0;
      for (i = 0; i < `IMH_SETS; i = i + 1) begin
        set_fp[i] <= 32'h00000000;
      end
    end else begin
      event_fault <= 1'b0;
      go_idle     <= 1'b0;
      go_stopped  <= 1'b0;
      start_init  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (msg_in) begin
            // Hold off new work and pins until done
            msg_ready <= 1'b0;
            irq_hold  <= 1'b1;
            state     <= ST_DONE;
            case (msg_type)
              `IMH_T_NOTICE: begin
                if (sel_ok && proc_state != `IMH_PS_INTR) begin
                  state <= ST_NC_RD;
                end
              end
              `IMH_T_CONTINIT: begin
                if (is_init_proc) begin
                  go_idle    <= 1'b1;
                  start_init <= 1'b1;
                end else begin
                  go_stopped <= 1'b1;
                end
              end
              `IMH_T_FLUSHLR: begin
                if (page_hit && !no_flush) begin
                  set_cnt  <= 2'h0;
                  word_cnt <= 4'h0;
                  state    <= ST_FL_RD;
                end
              end
              default: begin
                state <= ST_DONE;
              end
            endcase
          end else if (ret_valid) begin
            active_set <= ret_set;
            if (set_purged[ret_set]) begin
              msg_ready <= 1'b0;
              set_cnt   <= ret_set;
              word_cnt  <= 4'h0;
              state     <= ST_RL;
            end
          end else if (call_valid) begin
            set_fp[call_set]     <= call_fp;
            set_valid[call_set]  <= 1'b1;
            set_purged[call_set] <= 1'b0;
            active_set           <= call_set;
          end
        end

        // Uncached read of the notice field
        ST_NC_RD: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= cur_pcb_base + `IMH_NOTICE_OFS;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            if ((mem_rdata & `IMH_EVF_MASK) != 32'h00000000) begin
              mem_wdata <= mem_rdata & ~`IMH_EVF_MASK;
              state     <= ST_NC_WR;
            end else begin
              state <= ST_DONE;
            end
          end
        end

        // Fault only once the cleared flags are in memory
        ST_NC_WR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we  <= 1'b1;
          end else if (mem_ack) begin
            mem_req     <= 1'b0;
            mem_we      <= 1'b0;
            event_fault <= 1'b1;
            state       <= ST_DONE;
          end
        end

        // Cache read issued; empty sets have no frame to write
        ST_FL_RD: begin
          if (set_valid[set_cnt]) begin
            state <= ST_FL_DAT;
          end else if (set_cnt == `IMH_LAST_SET) begin
            state <= ST_FL_MRK;
          end else begin
            set_cnt <= nxt_set;
          end
        end

        ST_FL_DAT: begin
          mem_wdata <= lr_rdata;
          mem_addr  <= word_addr(set_fp[set_cnt], word_cnt);
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          state     <= ST_FL_WR;
        end

        ST_FL_WR: begin
          if (mem_ack) begin
            mem_req  <= 1'b0;
            mem_we   <= 1'b0;
            word_cnt <= word_cnt + 4'h1;
            state    <= ST_FL_RD;
            if (last_wd) begin
              if (set_cnt == `IMH_LAST_SET) begin
                state <= ST_FL_MRK;
              end else begin
                set_cnt <= nxt_set;
              end
            end
          end
        end

        // Active frame keeps its live registers
        ST_FL_MRK: begin
          for (i = 0; i < `IMH_SETS; i = i + 1) begin
            set_purged[i] <= set_valid[i] &&
                             (active_set != i[1:0]);
          end
          state <= ST_DONE;
        end

        // Refill a purged set, one word per bus cycle
        ST_RL: begin
          if (!mem_req) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= word_addr(set_fp[set_cnt], word_cnt);
          end else if (mem_ack) begin
            mem_req  <= 1'b0;
            word_cnt <= word_cnt + 4'h1;
            if (last_wd) begin
              set_purged[set_cnt] <= 1'b0;
              state               <= ST_DONE;
            end
          end
        end

        ST_DONE: begin
          msg_ready <= 1'b1;
          irq_hold  <= 1'b0;
          state     <= ST_IDLE;
        end

        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: rtl/imh_consts.vh */
`ifndef IMH_CONSTS_VH
`define IMH_CONSTS_VH

// ==========================================================
// Message address and type codes
`define IMH_MSG_ADDR     32'hff000010
`define IMH_T_NOTICE     8'h90
`define IMH_T_CONTINIT   8'h92
`define IMH_T_FLUSHLR    8'h84

// ==========================================================
// Message layout: type in word 0 low byte, field 3 is word 1
`define IMH_TYPE_MSB     7
`define IMH_TYPE_LSB     0

// ==========================================================
// Control block notice field
`define IMH_NOTICE_OFS   32'h00000010
`define IMH_EVF_MASK     32'h000000ff

// ==========================================================
// Processor states as seen by the handler
`define IMH_PS_EXEC      2'h0
`define IMH_PS_INTR      2'h1
`define IMH_PS_IDLE      2'h2
`define IMH_PS_STOP      2'h3

// ==========================================================
// Register cache geometry and stack page size
`define IMH_SETS         4
`define IMH_SET_W        2
`define IMH_WORDS        16
`define IMH_IDX_W        4
`define IMH_LAST_SET     2'h3
`define IMH_LAST_WORD    4'hf
`define IMH_PAGE_LSB     12

`endif

/* File: rtl/imh_regcache.v */
`default_nettype none

// ==========================================================
// Local register cache storage, registered read
module imh_regcache (
  input  wire        sys_clk,  // clock
  input  wire        we,       // write strobe
  input  wire [5:0]  waddr,    // {set, index}
  input  wire [31:0] wdata,    // write data
  input  wire [5:0]  raddr,    // {set, index}
  output reg  [31:0] rdata     // data one cycle after raddr
);

  reg [31:0] mem [0:63];

  // No reset on storage; contents are defined by use
  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

/* File: verification/imh_handler_monitor.sv */
`default_nettype none
// ==========================================
// Protocol checker on the handler ports
module imh_handler_monitor (
  input wire logic        sys_clk,      // clock
  input wire logic        rstn,         // reset
  input wire logic        qmove_valid,  // move valid
  input wire logic [31:0] qmove_addr,   // move target
  input wire logic [31:0] qmove_w0,     // type word
  input wire logic [31:0] qmove_w1,     // field 3
  input wire logic [31:0] cur_pcb_sel,  // selector
  input wire logic [31:0] cur_pcb_base, // block base
  input wire logic [1:0]  proc_state,   // state
  input wire logic        is_init_proc, // initializer
  input wire logic        call_valid,   // call
  input wire logic        ret_valid,    // return
  input wire logic        mem_ack,      // ack
  input wire logic        mem_req,      // request
  input wire logic        mem_we,       // write
  input wire logic [31:0] mem_addr,     // address
  input wire logic        msg_ready,    // idle
  input wire logic        irq_hold,     // irq masked
  input wire logic        event_fault,  // fault
  input wire logic        go_idle,      // idle pulse
  input wire logic        go_stopped,   // stop pulse
  input wire logic        start_init    // init pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Message acceptance and its type byte
  wire       take = msg_ready && qmove_valid && qmove_addr == 32'hff000010;
  wire [7:0] ty   = qmove_w0[7:0];
  wire       sel_ok = qmove_w1 == 32'h0 || qmove_w1 == cur_pcb_sel;

  a_take_busy: assert property (take |=> !msg_ready && irq_hold)
    else $error("message not handled busy");
  a_init_go: assert property (take && ty == 8'h92 && is_init_proc
    |=> go_idle && start_init && !go_stopped)
    else $error("initializer did not start");
  a_other_stop: assert property (take && ty == 8'h92 && !is_init_proc
    |=> go_stopped && !go_idle && !start_init)
    else $error("other processor did not stop");
  a_miss_ignore: assert property (msg_ready && qmove_valid
    && qmove_addr != 32'hff000010 && !ret_valid && !call_valid
    |=> msg_ready)
    else $error("foreign address taken");
  a_notice_read: assert property (take && ty == 8'h90 && sel_ok
    && proc_state != 2'h1
    |=> ##1 mem_req && !mem_we && mem_addr == cur_pcb_base + 32'h10)
    else $error("notice word not read");
  a_notice_skip: assert property (take && ty == 8'h90
    && (!sel_ok || proc_state == 2'h1) |=> !mem_req [*3])
    else $error("notice check not skipped");
  a_flush_skip: assert property (take && ty == 8'h84
    && proc_state[1] |=> !mem_req [*3])
    else $error("flush ran while idle or stopped");
  a_fault_after: assert property ($rose(event_fault)
    |-> $past(mem_ack) && $past(mem_we))
    else $error("fault without flag write");
  a_req_hold: assert property (mem_req && !mem_ack
    |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("request changed before ack");
  a_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("request held after ack");
endmodule

bind imh_handler imh_handler_monitor mon_u (
  .sys_clk      (sys_clk),
  .rstn         (rstn),
  .qmove_valid  (qmove_valid),
  .qmove_addr   (qmove_addr),
  .qmove_w0     (qmove_w0),
  .qmove_w1     (qmove_w1),
  .cur_pcb_sel  (cur_pcb_sel),
  .cur_pcb_base (cur_pcb_base),
  .proc_state   (proc_state),
  .is_init_proc (is_init_proc),
  .call_valid   (call_valid),
  .ret_valid    (ret_valid),
  .mem_ack      (mem_ack),
  .mem_req      (mem_req),
  .mem_we       (mem_we),
  .mem_addr     (mem_addr),
  .msg_ready    (msg_ready),
  .irq_hold     (irq_hold),
  .event_fault  (event_fault),
  .go_idle      (go_idle),
  .go_stopped   (go_stopped),
  .start_init   (start_init)
);
`default_nettype wire

/* File: verification/imh_mem_model.sv */
`default_nettype none
// ==========================================
// Memory behind the handler, variable wait
module imh_mem_model (
  input wire logic        sys_clk,   // clock
  input wire logic        mem_req,   // request
  input wire logic        mem_we,    // write
  input wire logic [31:0] mem_addr,  // address
  input wire logic [31:0] mem_wdata, // write data
  input wire logic [3:0]  dly,       // wait cycles
  output logic            mem_ack,   // done pulse
  output logic [31:0]     mem_rdata  // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [logic [31:0]];
  logic [3:0]  cnt = 4'h0;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;
  // Ack after dly; data toggles except on read acks so stale reads show
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (cnt == dly) begin
        mem_ack <= 1'b1;
        cnt <= 4'h0;
        if (mem_we)
          mem[mem_addr] = mem_wdata;
        else
          mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
      end else
        cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/imh_handler_bench.sv */
`default_nettype none
module imh_handler_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] a, w0, w1, pre, post;
    logic [1:0]  st;
    logic        ini;
    logic [3:0]  ev;
    int          nw;
  } imh_row_t;
  logic sys_clk, rstn, qmove_valid, is_init_proc, call_valid, ret_valid;
  logic lr_we, mem_ack, mem_req, mem_we, msg_ready, irq_hold;
  logic event_fault, go_idle, go_stopped, start_init;
  logic [31:0] qmove_addr, qmove_w0, qmove_w1, qmove_w2, qmove_w3;
  logic [31:0] cur_pcb_sel, cur_pcb_base, call_fp, lr_wdata, lr_rdata;
  logic [31:0] mem_rdata, mem_addr, mem_wdata;
  logic [1:0]  proc_state, call_set, ret_set;
  logic [5:0]  lr_waddr, lr_raddr;
  logic [3:0]  set_purged, ev, dly;
  int          err_count, n_checks, nw;
  // Columns: addr type field3 pre post state init {idle,init,stop,flt} nw
  imh_row_t rows [12] = '{
    '{32'hff000014, 32'h92, 0, 32'ha5, 32'ha5, 2'h0, 1, 4'h0, 0},
    '{32'hff000010, 32'h92, 0, 32'ha5, 32'ha5, 2'h0, 1, 4'hc, 0},
    '{32'hff000010, 32'h92, 0, 32'ha5, 32'ha5, 2'h0, 0, 4'h2, 0},
    '{32'hff000010, 32'h55, 0, 32'ha5, 32'ha5, 2'h0, 0, 4'h0, 0},
    '{32'hff000010, 32'h90, 0, 32'h123456a5, 32'h12345600, 2'h0, 0, 4'h1, 1},
    '{32'hff000010, 32'h90, 32'h77, 32'h1, 32'h0, 2'h0, 0, 4'h1, 1},
    '{32'hff000010, 32'h90, 32'h66, 32'ha5, 32'ha5, 2'h0, 0, 4'h0, 0},
    '{32'hff000010, 32'h90, 0, 32'ha5, 32'ha5, 2'h1, 0, 4'h0, 0},
    '{32'hff000010, 32'h90, 0, 32'h100, 32'h100, 2'h0, 0, 4'h0, 0},
    '{32'hff000010, 32'h84, 32'h9000, 32'h1, 32'h1, 2'h0, 0, 4'h0, 0},
    '{32'hff000010, 32'h84, 32'h2000, 32'h1, 32'h1, 2'h2, 0, 4'h0, 0},
    '{32'hff000010, 32'h84, 32'h2000, 32'h1, 32'h1, 2'h3, 0, 4'h0, 0}};

  imh_handler dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .qmove_valid(qmove_valid),
    .qmove_addr(qmove_addr), .qmove_w0(qmove_w0), .qmove_w1(qmove_w1),
    .qmove_w2(qmove_w2), .qmove_w3(qmove_w3), .cur_pcb_sel(cur_pcb_sel),
    .cur_pcb_base(cur_pcb_base), .proc_state(proc_state),
    .is_init_proc(is_init_proc), .call_valid(call_valid),
    .call_set(call_set), .call_fp(call_fp), .ret_valid(ret_valid),
    .ret_set(ret_set), .lr_we(lr_we), .lr_waddr(lr_waddr),
    .lr_wdata(lr_wdata), .lr_raddr(lr_raddr), .lr_rdata(lr_rdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .msg_ready(msg_ready), .irq_hold(irq_hold),
    .event_fault(event_fault), .go_idle(go_idle),
    .go_stopped(go_stopped), .start_init(start_init),
    .set_purged(set_purged));
  imh_mem_model mem_u (
    .sys_clk(sys_clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .dly(dly),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================
  // Clock, watchdog, helpers
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    err_count++;
    results();
  end
  task automatic results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Gather pulses and write acks until the handler is free again
  task automatic wait_done;
    int i;
    ev = 4'h0;
    nw = 0;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      ev |= {go_idle, start_init, go_stopped, event_fault};
      if (mem_ack && mem_we) nw++;
      if (msg_ready && i > 0) break;
    end
    if (i == 400) chk(32'h0, 32'h1, "handler hung");
  endtask
  task automatic send(input logic [31:0] a, w0, w1);
    do @(posedge sys_clk); while (msg_ready !== 1'b1);
    qmove_addr <= a;
    qmove_w0 <= w0;
    qmove_w1 <= w1;
    qmove_valid <= 1'b1;
    @(posedge sys_clk);
    qmove_valid <= 1'b0;
    wait_done();
  endtask
  task automatic bind_set(input logic [1:0] s, input logic [31:0] fp);
    call_set <= s;
    call_fp <= fp;
    call_valid <= 1'b1;
    @(posedge sys_clk);
    call_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {rstn, qmove_valid, is_init_proc, call_valid, ret_valid, lr_we} = '0;
    {qmove_addr, qmove_w0, qmove_w1, call_fp, lr_wdata} = '0;
    {proc_state, call_set, ret_set, lr_waddr, lr_raddr, dly} = '0;
    qmove_w2 = 32'hdeadbeef;
    qmove_w3 = 32'hcafef00d;
    cur_pcb_sel = 32'h77;
    cur_pcb_base = 32'h4000;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    chk(32'(msg_ready), 32'h1, "ready in reset");
    chk(32'(set_purged), 32'h0, "purged in reset");
    // Fill sets 0 and 1 while idle, then bind frames to them
    proc_state <= 2'h2;
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk);
      lr_we <= 1'b1;
      lr_waddr <= 6'(i);
      lr_wdata <= 32'ha0000000 + i;
    end
    @(posedge sys_clk);
    lr_we <= 1'b0;
    proc_state <= 2'h0;
    bind_set(2'h0, 32'h2000);
    bind_set(2'h1, 32'h3040);
    foreach (rows[k]) begin
      mem_u.mem[32'h4010] = rows[k].pre;
      proc_state <= rows[k].st;
      is_init_proc <= rows[k].ini;
      dly <= 4'(k % 4);
      send(rows[k].a, rows[k].w0, rows[k].w1);
      chk(32'(ev), 32'(rows[k].ev), "pulses");
      chk(32'(nw), 32'(rows[k].nw), "writes");
      chk(mem_u.mem[32'h4010], rows[k].post, "notice");
    end
    // Page hit: both sets written back, inactive one purged
    proc_state <= 2'h0;
    send(32'hff000010, 32'h84, 32'h2000);
    chk(32'(nw), 32'd32, "flush count");
    // Set 1 frame sits at 3040h, so its words follow at 3000h + 4i
    for (int i = 0; i < 32; i++)
      chk(mem_u.mem[32'h2000 + 4 * i + i / 16 * 32'h1000],
          32'ha0000000 + i, "flush");
    chk(32'(set_purged), 32'h1, "purged");
    chk(32'(irq_hold), 32'h0, "hold released");
    // Return into the purged set reloads it from the stack
    mem_u.mem[32'h200c] = 32'h5a5a5a5a;
    ret_set <= 2'h0;
    ret_valid <= 1'b1;
    @(posedge sys_clk);
    ret_valid <= 1'b0;
    wait_done();
    chk(32'(set_purged), 32'h0, "reload flag");
    lr_raddr <= 6'h03;
    repeat (2) @(posedge sys_clk);
    chk(lr_rdata, 32'h5a5a5a5a, "reload data");
    results();
  end
endmodule
`default_nettype wire
